/* File: src/pxs_port.sv */
// Purpose: Pin-level signalling of the PCI-X host port with strap inputs
// Assumes: rst is the bus reset, synchronous and active high
// Notes: Parity checked on the low 32-bit lanes only
//
// What this block does
// R1: Wide transfer via request/acknowledge 64 handshake
// R2: Reset clears state, all outputs released
// R3: Address parity error gives one-clock error pulse
// R4: As target, drive stop to end transaction
// R5: As initiator, end transaction when stopped
// R6: Data phase completes when both readies low
// R7: Width strap sets status bit 16
// R8: Mode strap selects compatibility or master-master
// R9: System holds test input low, output unused
// R10: Even parity over low address and command
// R11: Data parity error reported two clocks later
// R12: Compare computed address parity, pulse on mismatch
`timescale 1ns/1ps
module pxs_port
  import pxs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Straps and test
  input wire logic bus_width_strap_n,
  input wire logic dual_port_mode_strap_n,
  input wire logic factory_test_input,
  output logic factory_test_output,
  // Sampled bus control
  input wire pxs_ctl_s ctl_in,
  input wire logic [31:0] ad_in,
  input wire logic [3:0] cbe_n_in,
  input wire logic par_in,
  // Local requests
  input wire logic want_wide,
  input wire logic tgt_stop_req,
  input wire logic is_master,
  input wire logic is_target,
  input wire logic data_is_write,
  // Driven pins with enables
  output logic req64_n_out,
  output logic req64_oe,
  output logic ack64_n_out,
  output logic ack64_oe,
  output logic stop_n_out,
  output logic stop_oe,
  output logic serr_n_out,
  output logic serr_oe,
  output logic perr_n_out,
  output logic perr_oe,
  // Status
  output logic [STATUS_W-1:0] bus_status,
  output logic master_master_mode,
  output logic wide_active,
  output logic data_done,
  output logic master_abort_done
);

  ////////////////////////////////////////////////////////////////////////////
  logic [STATUS_W-1:0] status_reg;
  logic mode_reg;
  logic req64_reg;
  logic ack64_reg;
  logic stop_reg;
  logic serr_reg;
  logic [PERR_DELAY-1:0] perr_pipe_reg;
  logic wide_reg;
  logic done_reg;
  logic mabort_reg;
  logic addr_chk_reg;
  logic [31:0] addr_reg;
  logic [3:0] cmd_reg;
  logic [31:0] data_reg;
  logic [3:0] dbe_reg;
  logic data_chk_reg;
  logic frame_d_reg;
  pxs_phase_e phase_reg;
  logic phase_done;
  logic addr_start;

  assign phase_done = !ctl_in.irdy_n && !ctl_in.trdy_n; // R6
  assign addr_start = frame_d_reg && !ctl_in.frame_n;

  ////////////////////////////////////////////////////////////////////////////
  // Straps are re-sampled during reset so the status is settled at release
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= STATUS_RST;
      // High strap reports a 64-bit device
      status_reg[WIDE_FLAG_BIT] <= bus_width_strap_n; // R7
      mode_reg <= !dual_port_mode_strap_n; // R8
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_d_reg <= 1'b1;
      phase_reg <= PXS_IDLE;
    end else begin
      frame_d_reg <= ctl_in.frame_n;
      case (phase_reg)
        PXS_IDLE: if (addr_start) phase_reg <= PXS_ADDR;
        PXS_ADDR: phase_reg <= PXS_DATA;
        PXS_DATA: if (ctl_in.frame_n && ctl_in.irdy_n) phase_reg <= PXS_IDLE;
        default: phase_reg <= PXS_IDLE;
      endcase
    end
  end

  // Initiator asks for the wide path only when strapped wide
  always_ff @(posedge core_clk) begin
    if (rst) begin
      req64_reg <= 1'b0;
    end else begin
      req64_reg <= is_master && want_wide && status_reg[WIDE_FLAG_BIT]; // R1
    end
  end

  // Target accepts a wide request only on a wide bus
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack64_reg <= 1'b0;
    end else begin
      ack64_reg <= is_target && !ctl_in.req64_n &&
                   status_reg[WIDE_FLAG_BIT]; // R1
    end
  end

  // Wide only once both sides agreed; otherwise the transfer runs narrow
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wide_reg <= 1'b0;
    end else begin
      wide_reg <= (is_master && req64_reg && !ctl_in.ack64_n) ||
                  (is_target && ack64_reg); // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target stop, only while a frame is open
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= is_target && tgt_stop_req && !ctl_in.frame_n; // R4
    end
  end

  // Master ends its transaction when the claiming target stops it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mabort_reg <= 1'b0;
    end else begin
      mabort_reg <= is_master && !ctl_in.stop_n &&
                    !ctl_in.devsel_n; // R5
    end
  end

  // Completed data phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= phase_done; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address and command held for the parity that follows
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_reg <= 32'h0000_0000;
      cmd_reg <= 4'h0;
    end else if (addr_start) begin
      addr_reg <= ad_in;
      cmd_reg <= cbe_n_in;
    end
  end

  // Address parity is valid one clock after the address phase
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_chk_reg <= 1'b0;
    end else begin
      addr_chk_reg <= addr_start;
    end
  end

  // One-clock pulse; the external pull-up returns the pin high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      serr_reg <= 1'b0;
    end else begin
      serr_reg <= addr_chk_reg &&
                  ((^addr_reg ^ ^cmd_reg) != par_in); // R3 R10 R12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data held for its parity; only the receiving side checks it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_reg <= 32'h0000_0000;
      dbe_reg <= 4'h0;
      data_chk_reg <= 1'b0;
    end else begin
      data_chk_reg <= phase_done && (phase_reg != PXS_IDLE) &&
                      ((is_target && data_is_write) ||
                       (is_master && !data_is_write)); // R11
      if (phase_done) begin
        data_reg <= ad_in;
        dbe_reg <= cbe_n_in;
      end
    end
  end

  // Parity trails its data by a clock, so the data must be held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      perr_pipe_reg <= '0;
    end else begin
      perr_pipe_reg <= {perr_pipe_reg[PERR_DELAY-2:0],
                        data_chk_reg &&
                        ((^data_reg ^ ^dbe_reg) != par_in)}; // R10 R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables are reset-cleared so every pin floats while rst is high
  assign req64_n_out = !req64_reg;
  assign req64_oe = req64_reg; // R2
  assign ack64_n_out = !ack64_reg;
  assign ack64_oe = ack64_reg; // R2
  assign stop_n_out = !stop_reg;
  assign stop_oe = stop_reg; // R4
  assign serr_n_out = 1'b0; // R3
  assign serr_oe = serr_reg; // R3
  assign perr_n_out = !perr_pipe_reg[PERR_DELAY-1];
  assign perr_oe = perr_pipe_reg[PERR_DELAY-1]; // R11
  assign bus_status = status_reg;
  assign master_master_mode = mode_reg;
  assign wide_active = wide_reg;
  assign data_done = done_reg;
  assign master_abort_done = mabort_reg;
  // Test pin is not functional; parked low
  assign factory_test_output = 1'b0 & factory_test_input; // R9
endmodule

/* File: src/pxs_pkg.sv */
// Purpose: Shared constants and types for the PCI-X host port signalling block
// Assumes: Bus pins sampled synchronously to core_clk
// Notes: Active-low pins carry an _n suffix
package pxs_pkg;
  localparam int unsigned WIDE_FLAG_BIT = 16;
  localparam int unsigned STATUS_W = 32;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam int unsigned PERR_DELAY = 2;
  localparam int unsigned SERR_CYCLES = 1;

  // Sampled bus pin levels
  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic stop_n;
    logic devsel_n;
    logic req64_n;
    logic ack64_n;
  } pxs_ctl_s;

  typedef enum logic [1:0] {PXS_IDLE, PXS_ADDR, PXS_DATA} pxs_phase_e;
endpackage

/* File: test/pxs_port_asserts.sv */
// Purpose: port checks
// Assumes: top ports only
// Notes: bound at foot
`timescale 1ns/1ps
module pxs_port_asserts import pxs_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Local requests
  input wire logic want_wide,
  input wire logic tgt_stop_req,
  input wire logic is_master,
  input wire logic is_target,
  // Sampled bus
  input wire pxs_ctl_s ctl_in,
  input wire logic [31:0] ad_in,
  input wire logic [3:0] cbe_n_in,
  input wire logic par_in,
  // Watched outputs
  input wire logic req64_oe,
  input wire logic ack64_oe,
  input wire logic stop_oe,
  input wire logic serr_oe,
  input wire logic perr_oe,
  input wire logic data_done,
  input wire logic master_abort_done,
  input wire logic [31:0] bus_status
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence addr_ph; $fell(ctl_in.frame_n); endsequence
  sequence par_bad; ^{$past(ad_in), $past(cbe_n_in), par_in}; endsequence
  addr_par_a: assert property (addr_ph ##1 par_bad |=> serr_oe)
    else $error("no serr");
  serr_pulse_a: assert property (serr_oe |=> !serr_oe)
    else $error("serr long");
  reset_quiet_a:
    assert property ($past(rst) |-> !(req64_oe || ack64_oe || stop_oe ||
      serr_oe || perr_oe)) else $error("drive in reset");
  done_pair_a:
    assert property (!ctl_in.irdy_n && !ctl_in.trdy_n |=> data_done)
    else $error("no done");
  tgt_stop_a:
    assert property (is_target && tgt_stop_req && !ctl_in.frame_n |=> stop_oe)
    else $error("no stop");
  abort_end_a:
    assert property (is_master && !ctl_in.stop_n && !ctl_in.devsel_n
      |=> master_abort_done) else $error("no abort");
  req_wide_a:
    assert property (is_master && want_wide && bus_status[WIDE_FLAG_BIT]
      |=> req64_oe)
    else $error("no req64");
  narrow_bus_a:
    assert property (!bus_status[WIDE_FLAG_BIT] |-> !req64_oe && !ack64_oe)
    else $error("wide on narrow");
  perr_late_a:
    assert property (perr_oe |-> $past(data_done, 2))
    else $error("perr without data phase");
endmodule
bind pxs_port pxs_port_asserts u_chk (.*);

/* File: test/pxs_agent.sv */
// Purpose: bus agent model
// Assumes: bench sets want
// Notes: moves after posedge
`timescale 1ns/1ps
module pxs_agent import pxs_pkg::*; (
  // Clock and fault injection
  input wire logic core_clk,
  input wire logic bad,
  // Wanted pin levels
  input wire pxs_ctl_s want,
  // Bus as the block samples it
  output pxs_ctl_s ctl,
  output logic [31:0] ad,
  output logic [3:0] cbe_n,
  output logic par
);
  initial {ad, cbe_n} = 36'h0_0000_0006;
  always @(posedge core_clk) begin
    ctl <= want;
    // Released lanes toggle so stale data never looks valid
    ad <= want.frame_n ? ~ad : 32'hA5C3_0F96;
    par <= ^{ad, cbe_n} ^ bad;
  end
endmodule

/* File: test/pxs_port_tb.sv */
// Purpose: directed bench
// Assumes: agent drives bus
// Notes: falling-edge stimulus
`timescale 1ns/1ps
module pxs_port_tb import pxs_pkg::*;;
  logic core_clk = 0, rst = 1, bad = 0, want_wide = 0, tgt_stop_req = 0;
  logic bus_width_strap_n, dual_port_mode_strap_n, is_master = 0, par_in;
  logic is_target = 0, data_is_write = 0, factory_test_input = 0;
  logic factory_test_output, req64_n_out, req64_oe, ack64_n_out, ack64_oe;
  logic stop_n_out, stop_oe, serr_n_out, serr_oe, perr_n_out, perr_oe;
  logic master_master_mode, wide_active, data_done, master_abort_done;
  logic [31:0] ad_in, bus_status;
  logic [3:0] cbe_n_in;
  pxs_ctl_s want = 7'h7F, ctl_in;
  int num_errors = 0, tests_run = 0;
  pxs_agent u_agt (.core_clk, .bad, .want, .ctl(ctl_in), .ad(ad_in),
    .cbe_n(cbe_n_in), .par(par_in));
  pxs_port DUT (.*);
  always #10 core_clk = ~core_clk;
  task chk(string n, logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Pattern bits: frame,irdy,trdy,stop,devsel,req64,ack64
  task go(logic [6:0] v, int n);
    want = v;
    repeat (n) @(negedge core_clk);
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task t_reset(logic w);
    {rst, bus_width_strap_n, dual_port_mode_strap_n} = {1'h1, w, w};
    go(7'h7F, 4);
    chk("status", 32'(w) << WIDE_FLAG_BIT, bus_status);
    chk("mode", !w, master_master_mode);
    chk("oe rst", 5'h00, {req64_oe, ack64_oe, stop_oe, serr_oe, perr_oe});
    chk("test out", 1'h0, factory_test_output);
    rst = 1'h0;
  endtask
  task t_addr(logic b);
    bad = b;
    go(7'h3F, 3);
    chk("serr", {b, 1'h0}, {serr_oe, serr_n_out});
    bad = 1'h0;
    go(7'h7F, 1);
    chk("serr end", 1'h0, serr_oe);
  endtask
  task t_data(logic b);
    {is_target, data_is_write} = 2'h3;
    go(7'h3F, 1);
    go(7'h0F, 1);
    bad = b;
    go(7'h0F, 1);
    chk("done", 1'h1, data_done);
    bad = 1'h0;
    go(7'h7F, 2);
    chk("perr", {b, !b}, {perr_oe, perr_n_out});
    go(7'h7F, 2);
    chk("perr end", 1'h0, perr_oe);
    {is_target, data_is_write} = 2'h0;
  endtask
  task t_stop;
    {is_target, tgt_stop_req} = 2'h3;
    go(7'h3F, 2);
    chk("stop", 2'h2, {stop_oe, stop_n_out});
    {is_target, tgt_stop_req, is_master} = 3'h1;
    go(7'h73, 2);
    chk("abort", 2'h2, {master_abort_done, stop_oe});
    is_master = 1'h0;
  endtask
  task t_wide(logic w);
    {is_master, want_wide} = 2'h3;
    go(7'h7E, 3);
    chk("wide", {w, w, !w}, {req64_oe, wide_active, req64_n_out});
    {is_master, is_target} = 2'h1;
    go(7'h7D, 2);
    chk("ack64", {w, !w}, {ack64_oe, ack64_n_out});
    {is_target, want_wide} = 2'h0;
  endtask
  initial begin
    t_reset(1'h1);
    t_addr(1'h0);
    t_addr(1'h1);
    t_data(1'h0);
    t_data(1'h1);
    t_stop;
    t_wide(1'h1);
    t_reset(1'h0);
    t_wide(1'h0);
    summarize;
  end
  initial begin
    #4000;
    num_errors++;
    summarize;
  end
endmodule
